// *** hw/tdc_acq_pkg.sv ***
/*
 * Constants for the sweep acquisition and event formatting block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 25 MHz time base, one clock per elementary dwell time.
 */
package tdc_acq_pkg;

	// clock and timing
	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned DWELL_GROUP    = 64;
	localparam int unsigned BIN_SHIFT_MAX  = 24;
	localparam int unsigned BIN_WIDTH_MAX  = 1677216;
	localparam int unsigned DELAY_STEP_PS  = 3200;
	localparam int unsigned DELAY_MAX_PS   = 48000;
	localparam int unsigned DELAY_STEPS    = DELAY_MAX_PS / DELAY_STEP_PS;
	localparam int unsigned PULSER_DIV_0   = 16;
	localparam int unsigned LED_BLINK_BIT  = 22;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_BINSHIFT  = 8'h08;
	localparam logic [7:0] OFS_RANGE     = 8'h0C;
	localparam logic [7:0] OFS_PERIODS   = 8'h10;
	localparam logic [7:0] OFS_ACQDLY    = 8'h14;
	localparam logic [7:0] OFS_HOLD      = 8'h18;
	localparam logic [7:0] OFS_TPRESET   = 8'h1C;
	localparam logic [7:0] OFS_ROI_LO    = 8'h20;
	localparam logic [7:0] OFS_ROI_HI    = 8'h24;
	localparam logic [7:0] OFS_ROI_PRE   = 8'h28;
	localparam logic [7:0] OFS_CYCLES    = 8'h2C;
	localparam logic [7:0] OFS_INCFG     = 8'h30;
	localparam logic [7:0] OFS_MISC      = 8'h34;
	localparam logic [7:0] OFS_SWEEPCNT  = 8'h38;
	localparam logic [7:0] OFS_LOST      = 8'h3C;

	// control register fields
	localparam int unsigned CTRL_RUN      = 0;
	localparam int unsigned CTRL_ENDLESS  = 1;
	localparam int unsigned CTRL_SOFTSTRT = 2;
	localparam int unsigned CTRL_FOLDED   = 3;
	localparam int unsigned CTRL_SEQ      = 4;
	localparam int unsigned CTRL_TPRE_EN  = 5;
	localparam int unsigned CTRL_ROI_EN   = 6;
	localparam int unsigned CTRL_NO_SWEEP = 7;
	localparam int unsigned CTRL_ALLOW6   = 8;
	localparam int unsigned CTRL_LOSTBIT  = 9;
	localparam int unsigned CTRL_TEST     = 10;
	localparam int unsigned CTRL_TAGBIN   = 11;

	// status register fields
	localparam int unsigned STAT_DONE     = 0;
	localparam int unsigned STAT_STATE    = 4;
	localparam int unsigned STAT_CYCLE    = 16;

	// input and misc fields
	localparam int unsigned INCFG_EN      = 0;
	localparam int unsigned INCFG_PULSE   = 8;
	localparam int unsigned INCFG_EDGE    = 16;
	localparam int unsigned MISC_DELAY    = 0;
	localparam int unsigned MISC_PSEL     = 8;

	// event word fields
	localparam int unsigned EVW_EDGE      = 3;
	localparam int unsigned EVW_LOST      = 4;
	localparam int unsigned SWEEP_W       = 16;

	// reset values
	localparam logic [31:0] RST_CTRL     = 32'h0000_0100;
	localparam logic [31:0] RST_RANGE    = 32'h0000_1000;
	localparam logic [31:0] RST_PERIODS  = 32'h0000_0001;
	localparam logic [31:0] RST_CYCLES   = 32'h0001_0001;
	localparam logic [31:0] RST_INCFG    = 32'h0000_003F;

	// edge selection codes
	typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_OFF} edge_sel_t;

endpackage

// *** hw/tdc_sweep_acquisition_control.sv ***
/*
 * Sweep acquisition control and event word formatting for a six-input
 * multi-stop time-to-digital converter, with an APB register slave.
 * Assumes input pulses already synchronous to i_clk, one clock per
 * elementary dwell time, and a sink that drains event words via ready.
 */
// Function
// - bin width scaled by power of two
// - drop events before acquisition delay
// - hold time blocks next sweep start
// - word length two to eight bytes
// - channels push independently, sweep count embedded
// - six-byte words can be forbidden
// - optional data-lost flag in word
// - per-input internal pulser, blinking indicator
// - common programmable input delay
// - edge reported in fixed bit
// - time preset ends acquisition
// - folded sweep spans range times periods
// - sequential cycles and sequences
// - one-hot tag gives n plus two rows
// - binary tag gives pattern as row
// - time counter ticks per dwell group
// - endless time runs, channel wraps
`timescale 1ns/1ps
module tdc_sweep_acquisition_control #(
	parameter int unsigned TAG_W = 4,
	parameter int unsigned NCH   = 6
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [7:0]        i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_start,
	input  wire logic [4:0]        i_stop_inputs,
	input  wire logic [TAG_W-1:0]  i_tag,
	output logic      [63:0]       o_evt_data,
	output logic      [3:0]        o_evt_bytes,
	output logic      [15:0]       o_evt_row,
	output logic                   o_evt_valid,
	input  wire logic              i_evt_ready,
	output logic      [NCH-1:0]    o_led,
	output logic      [15:0]       o_mem_part,
	output logic                   o_running
);

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SWEEP, ST_HOLD} state_t;

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic [31:0] ctrl_q, binshift_q, range_q, periods_q, acqdly_q, hold_q;
	logic [31:0] tpre_q, roi_lo_q, roi_hi_q, roi_pre_q, cycles_q, incfg_q, misc_q;
	logic        done_q;
	logic [31:0] sweepcnt_q;
	logic [NCH-1:0] lost_q;
	logic [15:0] cycle_q, seq_q;
	state_t      state_q;
	logic        stop_hw;
	logic [31:0] rd_mux;
	logic        rd_ok;

	wire         wr_en  = i_psel && i_penable && i_pwrite;
	wire         setup  = i_psel && !i_penable;
	wire [31:0]  status = {cycle_q, 8'h00, 2'h0, state_q, 3'h0, done_q};

	// read decode; unmapped offsets answer with an error
	always_comb
	begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (i_paddr)
			tdc_acq_pkg::OFS_CTRL:     rd_mux = ctrl_q;
			tdc_acq_pkg::OFS_STATUS:   rd_mux = status;
			tdc_acq_pkg::OFS_BINSHIFT: rd_mux = binshift_q;
			tdc_acq_pkg::OFS_RANGE:    rd_mux = range_q;
			tdc_acq_pkg::OFS_PERIODS:  rd_mux = periods_q;
			tdc_acq_pkg::OFS_ACQDLY:   rd_mux = acqdly_q;
			tdc_acq_pkg::OFS_HOLD:     rd_mux = hold_q;
			tdc_acq_pkg::OFS_TPRESET:  rd_mux = tpre_q;
			tdc_acq_pkg::OFS_ROI_LO:   rd_mux = roi_lo_q;
			tdc_acq_pkg::OFS_ROI_HI:   rd_mux = roi_hi_q;
			tdc_acq_pkg::OFS_ROI_PRE:  rd_mux = roi_pre_q;
			tdc_acq_pkg::OFS_CYCLES:   rd_mux = cycles_q;
			tdc_acq_pkg::OFS_INCFG:    rd_mux = incfg_q;
			tdc_acq_pkg::OFS_MISC:     rd_mux = misc_q;
			tdc_acq_pkg::OFS_SWEEPCNT: rd_mux = sweepcnt_q;
			tdc_acq_pkg::OFS_LOST:     rd_mux = {26'h0, lost_q};
			default:                   rd_ok  = 1'b0;
		endcase
	end

	// zero-wait answer in the access phase
	assign o_pready  = i_penable;
	assign o_pslverr = i_psel && i_penable && !rd_ok;

	// read data captured in the setup cycle
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_prdata <= 32'h0000_0000;
		else if (setup)
			o_prdata <= rd_mux;
	end

	// configuration writes; hardware stop clears the run bit
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ctrl_q     <= tdc_acq_pkg::RST_CTRL;
			binshift_q <= 32'h0000_0000;
			range_q    <= tdc_acq_pkg::RST_RANGE;
			periods_q  <= tdc_acq_pkg::RST_PERIODS;
			acqdly_q   <= 32'h0000_0000;
			hold_q     <= 32'h0000_0000;
			tpre_q     <= 32'h0000_0000;
			roi_lo_q   <= 32'h0000_0000;
			roi_hi_q   <= 32'h0000_0000;
			roi_pre_q  <= 32'h0000_0000;
			cycles_q   <= tdc_acq_pkg::RST_CYCLES;
			incfg_q    <= tdc_acq_pkg::RST_INCFG;
			misc_q     <= 32'h0000_0000;
		end
		else
		begin
			if (wr_en)
			begin
				unique case (i_paddr)
					tdc_acq_pkg::OFS_CTRL:     ctrl_q     <= i_pwdata;
					tdc_acq_pkg::OFS_BINSHIFT: binshift_q <= (i_pwdata > 32'(tdc_acq_pkg::BIN_SHIFT_MAX)) ?
						32'(tdc_acq_pkg::BIN_SHIFT_MAX) : i_pwdata;
					tdc_acq_pkg::OFS_RANGE:    range_q    <= i_pwdata;
					tdc_acq_pkg::OFS_PERIODS:  periods_q  <= i_pwdata;
					tdc_acq_pkg::OFS_ACQDLY:   acqdly_q   <= i_pwdata;
					tdc_acq_pkg::OFS_HOLD:     hold_q     <= i_pwdata;
					tdc_acq_pkg::OFS_TPRESET:  tpre_q     <= i_pwdata;
					tdc_acq_pkg::OFS_ROI_LO:   roi_lo_q   <= i_pwdata;
					tdc_acq_pkg::OFS_ROI_HI:   roi_hi_q   <= i_pwdata;
					tdc_acq_pkg::OFS_ROI_PRE:  roi_pre_q  <= i_pwdata;
					tdc_acq_pkg::OFS_CYCLES:   cycles_q   <= i_pwdata;
					tdc_acq_pkg::OFS_INCFG:    incfg_q    <= i_pwdata;
					tdc_acq_pkg::OFS_MISC:     misc_q     <= i_pwdata;
					default:                   ;
				endcase
			end
			if (stop_hw)
				ctrl_q[tdc_acq_pkg::CTRL_RUN] <= 1'b0;
		end
	end

	wire run_en   = ctrl_q[tdc_acq_pkg::CTRL_RUN];
	wire endless  = ctrl_q[tdc_acq_pkg::CTRL_ENDLESS];
	wire folded   = ctrl_q[tdc_acq_pkg::CTRL_FOLDED];
	wire seq_en   = ctrl_q[tdc_acq_pkg::CTRL_SEQ];
	wire lost_opt = ctrl_q[tdc_acq_pkg::CTRL_LOSTBIT];
	wire test_en  = ctrl_q[tdc_acq_pkg::CTRL_TEST];

	////////////////////////////////////////////////////////////////////////
	// inputs: pulser, common delay, edge detection

	logic [23:0] pdiv_q;
	logic [NCH-1:0] dly_q [tdc_acq_pkg::DELAY_STEPS];
	logic [NCH-1:0] prev_q;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			pdiv_q <= 24'h00_0000;
		else
			pdiv_q <= pdiv_q + 24'h00_0001;
	end

	// pulser rate chosen from four divider taps
	wire [1:0] psel     = misc_q[tdc_acq_pkg::MISC_PSEL +: 2];
	wire       pulser   = pdiv_q[tdc_acq_pkg::PULSER_DIV_0 - 4 * 32'(psel)];
	wire [NCH-1:0] route = incfg_q[tdc_acq_pkg::INCFG_PULSE +: NCH] & {NCH{test_en}};
	wire [NCH-1:0] ch_en = incfg_q[tdc_acq_pkg::INCFG_EN +: NCH];
	wire [NCH-1:0] raw   = ({i_stop_inputs, i_start} & ~route) | ({NCH{pulser}} & route);

	// indicator: steady when enabled, blinking while pulser-fed
	assign o_led = ch_en & (~route | {NCH{pdiv_q[tdc_acq_pkg::LED_BLINK_BIT]}});

	// common delay line, tap chosen in whole steps
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			dly_q <= '{default: '0};
		else
			dly_q <= {dly_q[1:tdc_acq_pkg::DELAY_STEPS-1], raw};
	end

	wire [3:0] dsel = misc_q[tdc_acq_pkg::MISC_DELAY +: 4];
	wire [NCH-1:0] delayed = (dsel == 4'h0) ? raw :
		dly_q[tdc_acq_pkg::DELAY_STEPS - 32'(dsel)];

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			prev_q <= '0;
		else
			prev_q <= delayed;
	end

	// per-input trigger by selected edge, fall flag kept
	logic [NCH-1:0] hit, fall;
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			fall[c] = prev_q[c] && !delayed[c];
			unique case (tdc_acq_pkg::edge_sel_t'(incfg_q[tdc_acq_pkg::INCFG_EDGE + 2*c +: 2]))
				tdc_acq_pkg::EDGE_RISE: hit[c] = !prev_q[c] && delayed[c];
				tdc_acq_pkg::EDGE_FALL: hit[c] = fall[c];
				tdc_acq_pkg::EDGE_BOTH: hit[c] = prev_q[c] != delayed[c];
				tdc_acq_pkg::EDGE_OFF:  hit[c] = 1'b0;
			endcase
			hit[c] = hit[c] && ch_en[c];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sweep timing

	logic [5:0]  grp_q;
	logic [31:0] time_q, bin_q, fold_q, hcnt_q, run_t_q, roi_cnt_q;
	wire  [31:0] bmask    = (32'h0000_0001 << binshift_q[4:0]) - 32'h0000_0001;
	wire         t_tick   = grp_q == 6'(tdc_acq_pkg::DWELL_GROUP - 1);
	wire         b_tick   = t_tick && ((time_q & bmask) == bmask);
	wire  [31:0] sw_len   = folded ? 32'(range_q * periods_q) : range_q;
	wire         sw_end   = !endless && b_tick && (bin_q + 32'h1 >= sw_len);
	wire         in_acq   = bin_q >= acqdly_q;
	wire         start_ev = ctrl_q[tdc_acq_pkg::CTRL_SOFTSTRT] || hit[0];
	wire         tpre_hit = ctrl_q[tdc_acq_pkg::CTRL_TPRE_EN] && run_t_q >= tpre_q;
	wire         roi_hit  = ctrl_q[tdc_acq_pkg::CTRL_ROI_EN] && roi_cnt_q > roi_pre_q;
	wire         preset   = (state_q != ST_IDLE) && (tpre_hit || roi_hit);
	wire         last_cyc = !seq_en || ((cycle_q + 16'h1 >= cycles_q[15:0]) &&
		(seq_q + 16'h1 >= cycles_q[31:16]));
	assign stop_hw   = preset && last_cyc;
	assign o_running = state_q == ST_SWEEP;
	assign o_mem_part = cycle_q;

	// sweep state: starts only accepted while armed
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !run_en)
			state_q <= ST_IDLE;
		else
		begin
			unique case (state_q)
				ST_IDLE:  state_q <= ST_ARMED;
				ST_ARMED: if (start_ev) state_q <= ST_SWEEP;
				ST_SWEEP: if (sw_end) state_q <= (hold_q != 0) ? ST_HOLD : ST_ARMED;
				ST_HOLD:  if (t_tick && hcnt_q + 32'h1 >= hold_q) state_q <= ST_ARMED;
			endcase
		end
	end

	// dwell group also runs in hold-off, else the hold count never ticks
	always_ff @(posedge i_clk)
	begin
		if (i_rst || state_q == ST_IDLE || state_q == ST_ARMED)
			grp_q <= 6'h00;
		else
			grp_q <= grp_q + 6'h01;
	end

	// time, bin and folded channel counters
	always_ff @(posedge i_clk)
	begin
		if (i_rst || state_q != ST_SWEEP)
		begin
			time_q <= 32'h0000_0000;
			bin_q  <= 32'h0000_0000;
			fold_q <= 32'h0000_0000;
		end
		else
		begin
			if (t_tick)
				time_q <= time_q + 32'h1;
			if (b_tick)
			begin
				bin_q  <= bin_q + 32'h1;
				fold_q <= (fold_q + 32'h1 >= range_q) ? 32'h0 : fold_q + 32'h1;
			end
		end
	end

	// hold-off, run time, sweep count and cycle counters
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			hcnt_q     <= 32'h0;
			run_t_q    <= 32'h0;
			sweepcnt_q <= 32'h0;
			cycle_q    <= 16'h0;
			seq_q      <= 16'h0;
			done_q     <= 1'b0;
		end
		else
		begin
			hcnt_q <= (state_q != ST_HOLD) ? 32'h0 : hcnt_q + {31'h0, t_tick};
			if (state_q != ST_IDLE && grp_q == 6'h00 && state_q == ST_SWEEP)
				run_t_q <= run_t_q + 32'h1;
			if (state_q == ST_ARMED && start_ev)
				sweepcnt_q <= sweepcnt_q + 32'h1;
			if (preset)
			begin
				run_t_q <= 32'h0;
				if (!last_cyc)
				begin
					cycle_q <= (cycle_q + 16'h1 >= cycles_q[15:0]) ? 16'h0 : cycle_q + 16'h1;
					if (cycle_q + 16'h1 >= cycles_q[15:0])
						seq_q <= seq_q + 16'h1;
				end
			end
			if (wr_en && i_paddr == tdc_acq_pkg::OFS_CTRL && i_pwdata[tdc_acq_pkg::CTRL_RUN] && !run_en)
			begin
				cycle_q <= 16'h0;
				seq_q   <= 16'h0;
				run_t_q <= 32'h0;
			end
			// done: hardware set wins over write-one clear
			if (stop_hw)
				done_q <= 1'b1;
			else if (wr_en && i_paddr == tdc_acq_pkg::OFS_STATUS && i_pwdata[tdc_acq_pkg::STAT_DONE])
				done_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel capture, overflow and word formatting

	logic [NCH-1:0] pend_q, pfall_q;
	logic [31:0]    ptime_q [NCH];
	logic [15:0]    prow_q  [NCH];
	logic [2:0]     grant;
	logic           gvalid;
	wire            take    = gvalid && (!o_evt_valid || i_evt_ready);
	wire [NCH-1:0]  accept  = hit & {NCH{state_q == ST_SWEEP && in_acq}};
	wire [31:0]     ev_time = endless ? time_q : fold_q;
	wire            roi_in  = (ev_time >= roi_lo_q) && (ev_time < roi_hi_q);

	// ROI event count, restarted for each run and after each preset
	always_ff @(posedge i_clk)
	begin
		if (i_rst || preset || state_q == ST_IDLE)
			roi_cnt_q <= 32'h0000_0000;
		else if (roi_in)
			roi_cnt_q <= roi_cnt_q + 32'($countones(accept));
	end

	// tag row: binary pattern or one-hot row with n+2 rows
	logic [15:0] tag_row;
	always_comb
	begin
		tag_row = 16'h0;
		if (ctrl_q[tdc_acq_pkg::CTRL_TAGBIN])
			tag_row = 16'(i_tag);
		else if (i_tag != '0)
		begin
			tag_row = 16'(TAG_W + 1);
			for (int b = 0; b < TAG_W; b++)
				if (i_tag == TAG_W'(1) << b)
					tag_row = 16'(b + 1);
		end
	end

	// lowest pending channel is emitted first
	always_comb
	begin
		grant  = 3'h0;
		gvalid = 1'b0;
		for (int c = NCH - 1; c >= 0; c--)
			if (pend_q[c])
			begin
				grant  = 3'(c);
				gvalid = 1'b1;
			end
	end

	// capture slots; a hit on a full slot marks data lost
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			pend_q  <= '0;
			pfall_q <= '0;
			lost_q  <= '0;
			ptime_q <= '{default: '0};
			prow_q  <= '{default: '0};
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (take && grant == 3'(c))
				begin
					pend_q[c] <= 1'b0;
					lost_q[c] <= 1'b0;
				end
				if (accept[c] && pend_q[c] && !(take && grant == 3'(c)))
					lost_q[c] <= 1'b1;
				else if (accept[c])
				begin
					pend_q[c]  <= 1'b1;
					pfall_q[c] <= fall[c];
					ptime_q[c] <= endless ? time_q : fold_q;
					prow_q[c]  <= tag_row;
				end
			end
		end
	end

	// field widths decide the word length
	logic [5:0] tbits, lowbits, need;
	logic [3:0] nbytes;
	always_comb
	begin
		tbits = 6'd1;
		for (int b = 1; b < 32; b++)
			if ((range_q - 32'h1) >> b != 0)
				tbits = 6'(b + 1);
		if (endless)
			tbits = 6'd32;
		lowbits = lost_opt ? 6'(tdc_acq_pkg::EVW_LOST + 1) : 6'(tdc_acq_pkg::EVW_EDGE + 1);
		need    = lowbits + tbits +
			(ctrl_q[tdc_acq_pkg::CTRL_NO_SWEEP] ? 6'd0 : 6'(tdc_acq_pkg::SWEEP_W));
		if (need <= 6'd16)
			nbytes = 4'd2;
		else if (need <= 6'd32)
			nbytes = 4'd4;
		else if (need <= 6'd48 && ctrl_q[tdc_acq_pkg::CTRL_ALLOW6])
			nbytes = 4'd6;
		else
			nbytes = 4'd8;
	end

	wire [63:0] w_time  = 64'(ptime_q[grant]) << lowbits;
	wire [63:0] w_sweep = ctrl_q[tdc_acq_pkg::CTRL_NO_SWEEP] ? 64'h0 :
		64'(sweepcnt_q[tdc_acq_pkg::SWEEP_W-1:0]) << (lowbits + tbits);
	wire [63:0] w_low   = {59'h0, lost_opt && lost_q[grant], pfall_q[grant], grant};

	// output word register with valid/ready
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_evt_valid <= 1'b0;
			o_evt_data  <= 64'h0;
			o_evt_bytes <= 4'h0;
			o_evt_row   <= 16'h0;
		end
		else if (take)
		begin
			o_evt_valid <= 1'b1;
			o_evt_data  <= w_sweep | w_time | w_low;
			o_evt_bytes <= nbytes;
			o_evt_row   <= prow_q[grant];
		end
		else if (i_evt_ready)
			o_evt_valid <= 1'b0;
	end

endmodule

// *** tb/tdc_acq_sva.sv ***
/*
 * Assertions on the ports of the sweep acquisition block.
 * Assumes one clock i_clk and synchronous active-high i_rst.
 */
`timescale 1ns/1ps
module tdc_acq_sva (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [63:0] o_evt_data,
	input wire logic [3:0]  o_evt_bytes,
	input wire logic        o_evt_valid,
	input wire logic        i_evt_ready,
	input wire logic [15:0] o_mem_part,
	input wire logic        o_running
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////
	// register bus answers
	chk_pready_zero_wait: assert property (i_psel && i_penable |-> o_pready)
		else $error("access phase without ready");
	chk_slverr_phase: assert property (o_pslverr |-> i_psel && i_penable)
		else $error("error flag outside access phase");
	chk_slverr_unmapped: assert property (i_psel && i_penable && i_paddr > 8'h3C |-> o_pslverr)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (i_psel && i_penable && i_paddr <= 8'h3C && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
		else $error("mapped access refused");
	chk_prdata_stands: assert property (!i_psel |=> $stable(o_prdata))
		else $error("read data moved while idle");

	////////////////////////////////////////////////////////////////
	// event stream
	chk_evt_hold: assert property (o_evt_valid && !i_evt_ready |=> o_evt_valid && $stable(o_evt_data) && $stable(o_evt_bytes))
		else $error("event word dropped or changed while stalled");
	chk_bytes_legal: assert property (o_evt_valid |-> o_evt_bytes inside {4'h2, 4'h4, 4'h6, 4'h8})
		else $error("illegal word length");
	chk_chan_code: assert property (o_evt_valid |-> o_evt_data[2:0] < 3'h6)
		else $error("channel code out of range");
	chk_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_evt_valid && !o_running && o_mem_part == 16'h0000)
		else $error("outputs active after reset");
endmodule

// *** tb/tdc_far_side.sv ***
/*
 * Far side of the block: detector lines and the host sink.
 * Assumes commands from the bench arrive one clock wide.
 */
`timescale 1ns/1ps
module tdc_far_side (
	input wire logic       i_clk,
	input wire logic       i_go,
	input wire logic [2:0] i_ch,
	input wire logic       i_slow,
	output logic           o_start,
	output logic [4:0]     o_stop_inputs,
	output logic           o_evt_ready
);
	int          seed = 41;
	logic [31:0] r;

	initial
	begin
		o_start = 1'b0;
		o_stop_inputs = 5'h00;
		o_evt_ready = 1'b1;
	end

	// lines flip level on command, sink stalls at random when slow
	always @(posedge i_clk)
	begin
		r = $random(seed);
		o_evt_ready <= !i_slow || r[0];
		if (i_go && i_ch == 3'h0)
			o_start <= !o_start;
		else if (i_go)
			o_stop_inputs[i_ch - 3'h1] <= !o_stop_inputs[i_ch - 3'h1];
	end
endmodule

// *** tb/tdc_sweep_acquisition_control_tb.sv ***
/*
 * Self-checking bench for the sweep acquisition block.
 * Assumes the far-side model and the checker are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tdc_sweep_acquisition_control_tb;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, exp_rd, incfg = 32'h0B93_001F;
	logic        pready, pslverr, start, evt_valid, evt_ready, running, cur_bin, lost_mode = 0, drop = 0, use_sw = 0;
	logic [4:0]  stops;
	logic [3:0]  tag = 4'h0, evt_bytes, cur_bytes;
	logic [2:0]  ch = 3'h0;
	logic [63:0] evt_data;
	logic [15:0] evt_row, mem_part;
	logic [5:0]  led, lvl = 6'h00;
	logic [23:0] eq[$], exp_evt;
	logic [31:0] rq[$];
	int          fails = 0, n_tests = 0, seed = 41, sw_n = 0, sw_sh = 0;
	logic [7:0]  ra[6] = '{tdc_acq_pkg::OFS_CTRL, tdc_acq_pkg::OFS_RANGE, tdc_acq_pkg::OFS_PERIODS,
		tdc_acq_pkg::OFS_CYCLES, tdc_acq_pkg::OFS_INCFG, 8'h40};
	logic [31:0] rv[6] = '{tdc_acq_pkg::RST_CTRL, tdc_acq_pkg::RST_RANGE, tdc_acq_pkg::RST_PERIODS,
		tdc_acq_pkg::RST_CYCLES, tdc_acq_pkg::RST_INCFG, 32'h0};
	// control, range, delay taps per configuration
	logic [31:0] cc[6] = '{32'h185, 32'h905, 32'h385, 32'h905, 32'h005, 32'h187};
	logic [31:0] cr[6] = '{32'h1000, 32'h1000, 32'h1000, 32'h0010_0000, 32'h0010_0000, 32'h1000};
	logic [31:0] cm[6] = '{32'h0, 32'hF, 32'h0, 32'h0, 32'h3, 32'h0};

	always #20 clk = ~clk;

	tdc_sweep_acquisition_control dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_start(start), .i_stop_inputs(stops), .i_tag(tag), .o_evt_data(evt_data),
		.o_evt_bytes(evt_bytes), .o_evt_row(evt_row), .o_evt_valid(evt_valid), .i_evt_ready(evt_ready),
		.o_led(led), .o_mem_part(mem_part), .o_running(running));
	tdc_far_side far (.i_clk(clk), .i_go(go), .i_ch(ch), .i_slow(slow), .o_start(start),
		.o_stop_inputs(stops), .o_evt_ready(evt_ready));

	////////////////////////////////////////////////////////////////
	// expectation helpers
	function automatic logic [15:0] rowf(input logic [3:0] t, input logic bin);
		if (bin)
			return {12'h000, t};
		if (t == 4'h0)
			return 16'h0000;
		if ($countones(t) == 1)
			return 16'($clog2(t)) + 16'h0001;
		return 16'h0005;
	endfunction

	function automatic logic [3:0] wbytes(input logic [31:0] ctl, input int tb);
		int b;
		b = 4 + ctl[9] + tb + (ctl[7] ? 0 : 16);
		if (b <= 16)
			return 4'h2;
		if (b <= 32)
			return 4'h4;
		if (b <= 48 && ctl[8])
			return 4'h6;
		return 4'h8;
	endfunction

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		if (!w)
			rq.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		`CHK(pslverr, a > 8'h3C)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic toggle(input int c);
		logic [31:0] r;
		logic        nl;
		logic [1:0]  code;
		r = $random(seed);
		nl = !lvl[c];
		lvl[c] = nl;
		code = 2'(incfg >> (16 + 2 * c));
		@(posedge clk);
		tag <= r[3:0];
		ch <= 3'(c);
		go <= 1'b1;
		if (!drop && incfg[c] && (code == 2'h2 || code == {1'b0, !nl}))
			eq.push_back({rowf(r[3:0], cur_bin), cur_bytes, !nl, 3'(c)});
		@(posedge clk);
		go <= 1'b0;
		for (int w = 0; w < 80 && eq.size() != 0; w++) @(posedge clk);
		repeat (4) @(posedge clk);
		`CHK(eq.size(), 0)
		eq.delete();
	endtask

	task automatic run_cfg(input logic [31:0] ctl, input logic [31:0] rng, input logic [31:0] misc);
		apb(tdc_acq_pkg::OFS_CTRL, 1'b1, 32'h0, 32'h0);
		apb(tdc_acq_pkg::OFS_RANGE, 1'b1, rng, 32'h0);
		apb(tdc_acq_pkg::OFS_MISC, 1'b1, misc, 32'h0);
		cur_bin = ctl[11];
		lost_mode = ctl[9];
		cur_bytes = wbytes(ctl, ctl[1] ? 32 : $clog2(rng));
		// each run starts exactly one sweep; count sits above edge, lost and time fields
		use_sw = !ctl[7];
		sw_sh = 4 + ctl[9] + (ctl[1] ? 32 : $clog2(rng));
		sw_n++;
		apb(tdc_acq_pkg::OFS_CTRL, 1'b1, ctl, 32'h0);
		repeat (4) @(posedge clk);
		for (int c = 1; c < 6; c++)
		begin
			toggle(c);
			toggle(c);
		end
	endtask

	task give_verdict;
		$display("checks=%0d errors=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// result watcher: oldest note against each word or read
	always @(posedge clk)
	begin
		if (!rst && evt_valid && evt_ready)
		begin
			exp_evt = (eq.size() != 0) ? eq.pop_front() : 24'hFFFFFF;
			`CHK({evt_row, evt_bytes, evt_data[3:0]}, exp_evt)
			if (lost_mode)
				`CHK(evt_data[4], 1'b0)
			if (use_sw)
				`CHK(evt_data[sw_sh +: 16], 16'(sw_n))
		end
		if (psel && penable && pready && !pwrite)
		begin
			exp_rd = (rq.size() != 0) ? rq.pop_front() : 32'hDEAD_BEEF;
			`CHK(prdata, exp_rd)
		end
	end

	// main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			apb(ra[i], 1'b0, 32'h0, rv[i]);
		apb(8'h40, 1'b1, 32'hFFFF_FFFF, 32'h0);
		apb(tdc_acq_pkg::OFS_BINSHIFT, 1'b1, 32'h1E, 32'h0);
		apb(tdc_acq_pkg::OFS_BINSHIFT, 1'b0, 32'h0, 32'h18);
		apb(tdc_acq_pkg::OFS_INCFG, 1'b1, incfg, 32'h0);
		@(posedge clk);
		`CHK(led, 6'h1F)
		for (int k = 0; k < 6; k++)
		begin
			slow <= k[0];
			run_cfg(cc[k], cr[k], cm[k]);
		end
		// events before the acquisition delay are discarded
		apb(tdc_acq_pkg::OFS_ACQDLY, 1'b1, 32'h800, 32'h0);
		drop = 1'b1;
		run_cfg(32'h905, 32'h1000, 32'h0);
		drop = 1'b0;
		// time preset ends an endless run
		apb(tdc_acq_pkg::OFS_CTRL, 1'b1, 32'h0, 32'h0);
		apb(tdc_acq_pkg::OFS_TPRESET, 1'b1, 32'h2, 32'h0);
		apb(tdc_acq_pkg::OFS_CTRL, 1'b1, 32'h127, 32'h0);
		repeat (8) @(posedge clk);
		`CHK(running, 1'b1)
		for (int w = 0; w < 400 && running === 1'b1; w++) @(posedge clk);
		`CHK(running, 1'b0)
		// done flag set by the preset, then cleared by writing one
		apb(tdc_acq_pkg::OFS_STATUS, 1'b0, 32'h0, 32'h1);
		apb(tdc_acq_pkg::OFS_STATUS, 1'b1, 32'h1, 32'h0);
		apb(tdc_acq_pkg::OFS_STATUS, 1'b0, 32'h0, 32'h0);
		// ROI preset of zero: the first event inside the window stops the run
		apb(tdc_acq_pkg::OFS_ACQDLY, 1'b1, 32'h0, 32'h0);
		apb(tdc_acq_pkg::OFS_ROI_HI, 1'b1, 32'h1000, 32'h0);
		apb(tdc_acq_pkg::OFS_CTRL, 1'b1, 32'h945, 32'h0);
		sw_n = sw_n + 2; // time-preset run and this run each start a sweep
		repeat (4) @(posedge clk);
		toggle(1);
		`CHK(running, 1'b0)
		// pulser-routed input goes dark until the blink bit turns
		apb(tdc_acq_pkg::OFS_CTRL, 1'b1, 32'h400, 32'h0);
		apb(tdc_acq_pkg::OFS_INCFG, 1'b1, incfg | 32'h200, 32'h0);
		@(posedge clk);
		`CHK(led, 6'h1D)
		give_verdict();
	end

	// watchdog
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		give_verdict();
	end
endmodule

bind tdc_sweep_acquisition_control tdc_acq_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_evt_data(o_evt_data), .o_evt_bytes(o_evt_bytes), .o_evt_valid(o_evt_valid),
	.i_evt_ready(i_evt_ready), .o_mem_part(o_mem_part), .o_running(o_running));
